// *** pkg/dtspm_pkg.sv ***
// Package for the debug, trace and serial pin multiplexer.
// Assumes one system clock; configuration arrives as plain ports.
package dtspm_pkg;

  // Configuration nibble code that selects the alternate output
  localparam logic [3:0] ALT_OUT_CODE = 4'h9;

  // Field positions inside the configuration words
  localparam int PA_HI_PIN5_LSB = 4;   // port_a_high_config[7:4]
  localparam int PB_LO_PIN1_LSB = 4;   // port_b_low_config[7:4]
  localparam int PB_LO_PIN0_LSB = 0;   // port_b_low_config[3:0]
  localparam int PC_LO_PIN2_LSB = 8;   // port_c_low_config[11:8]
  localparam int DBG_GPIO_BIT   = 5;   // debug_pin_config[5]

  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Trace port width that carries bit 3
  localparam logic [1:0] TRACE_WIDTH_4 = 2'h3;

  // Serial controller 1 modes
  localparam logic [1:0] SC_MODE_OFF  = 2'h0;
  localparam logic [1:0] SC_MODE_UART = 2'h1;
  localparam logic [1:0] SC_MODE_SPI  = 2'h2;

  // Debug protocol states
  typedef enum logic {DTSPM_JTAG, DTSPM_SWD} dtspm_dbg_t;

  // Drive of one pad: output value, output enable, pull-up, pull-down
  typedef struct packed {
    logic dout;
    logic oe;
    logic pu;
    logic pd;
  } dtspm_pad_t;

  // Processor trace settings
  typedef struct packed {
    logic       trace_en;
    logic       async_en;
    logic [1:0] sync_width;
  } dtspm_trace_t;

endpackage : dtspm_pkg

// *** rtl/dtspm_sync2.sv ***
// Two flip-flop synchroniser for a vector of pad inputs.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module dtspm_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // First stage feeds only the second
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : dtspm_sync2
`default_nettype wire

// *** rtl/dtspm_pin_mux.sv ***
// Pin function multiplexer for port A line 5, port B lines 0..2 and
// port C lines 2..4: trace, packet trace, serial controller 1, debug.
// Assumes config words and peripheral signals are on clk_sys; pad inputs
// and the reset pin are asynchronous and are synchronised here.
// Operation
// - Port A line 5 alternate needs nibble select
// - Boot strap sampled at pin reset release
// - Packet trace data only without processor trace
// - Trace bit 3 needs trace on, 4-wire
// - Port B line 1 carries serial out
// - Serial mode picks UART or SPI slave
// - Port B line 2 feeds serial input
// - Debug defaults to JTAG, reset returns it
// - Debug clock pin: JTAG clock, pull-down
// - Pull-ups on debug input pins C3, C4
// - Debug disable frees lines C2, C4
// - Line C3 free on disable or serial-wire
// - Async trace on C2 in serial-wire only
// - Trace clock on B0 with select
// - Port B line 0 feeds interrupt A
`timescale 1ns/1ns
`default_nettype none
module dtspm_pin_mux (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    pin_reset_n,
  input  wire logic [15:0]             port_a_high_config,
  input  wire logic [15:0]             port_b_low_config,
  input  wire logic [15:0]             port_c_low_config,
  input  wire logic [15:0]             debug_pin_config,
  input  wire dtspm_pkg::dtspm_trace_t trace_cfg,
  input  wire logic                    packet_trace_interface,
  input  wire logic                    packet_trace_data_out,
  input  wire logic                    trace_data_bit3,
  input  wire logic                    sync_trace_clock,
  input  wire logic                    swo_trace,
  input  wire logic [1:0]              serctl1_mode_select,
  input  wire logic                    serctl1_spi_control,
  input  wire logic                    serctl1_spi_slave_out,
  input  wire logic                    serctl1_uart_tx,
  input  wire logic                    swd_switch_req,
  input  wire logic                    jtag_data_out,
  input  wire logic                    jtag_data_out_en,
  input  wire logic                    swdio_out,
  input  wire logic                    swdio_oe,
  input  wire logic [6:0]              gpio_out,
  input  wire logic [6:0]              gpio_oe,
  input  wire logic [6:0]              pad_in,
  output var  dtspm_pkg::dtspm_pad_t   pad_a5,
  output var  dtspm_pkg::dtspm_pad_t   pad_b0,
  output var  dtspm_pkg::dtspm_pad_t   pad_b1,
  output var  dtspm_pkg::dtspm_pad_t   pad_b2,
  output var  dtspm_pkg::dtspm_pad_t   pad_dbg_clk,
  output var  dtspm_pkg::dtspm_pad_t   pad_c2,
  output var  dtspm_pkg::dtspm_pad_t   pad_c3,
  output var  dtspm_pkg::dtspm_pad_t   pad_c4,
  output var  logic                    serctl1_spi_slave_in,
  output var  logic                    serctl1_uart_rx,
  output var  logic                    jtag_clock_in,
  output var  logic                    jtag_data_in,
  output var  logic                    jtag_mode_select,
  output var  logic                    swclk_in,
  output var  logic                    swdio_in,
  output var  logic                    ext_interrupt_a,
  output var  logic [6:0]              gpio_in,
  output var  logic                    factory_info_block_monitor,
  output var  logic                    debug_swd_mode
);
  // Pad input vector order: 0 a5, 1 b0, 2 b2, 3 dbg clk, 4 c2, 5 c3, 6 c4
  logic [6:0] pad_sync;
  logic [1:0] rstn_sync;
  logic       rstn_meta;
  logic       rstn_q;
  logic       next_rstn_meta;
  logic       next_rstn_q;

  dtspm_sync2 #(.WIDTH(7)) u_pad_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // Reset pin synchroniser; the first stage is read by the second only
  always_comb begin
    next_rstn_meta = pin_reset_n;
    next_rstn_q    = rstn_meta;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rstn_meta <= 1'b0;
      rstn_q    <= 1'b0;
    end else begin
      rstn_meta <= next_rstn_meta;
      rstn_q    <= next_rstn_q;
    end
  end
  assign rstn_sync = {rstn_q, rstn_q};

  // Debug protocol state and boot strap capture
  dtspm_pkg::dtspm_dbg_t dbg_mode;
  dtspm_pkg::dtspm_dbg_t next_dbg_mode;
  logic                  strap_n;
  logic                  next_strap_n;
  logic                  next_fib;
  logic                  next_swd;

  always_comb begin
    next_dbg_mode = dbg_mode;
    next_strap_n  = strap_n;
    case (dbg_mode)
      dtspm_pkg::DTSPM_JTAG: if (swd_switch_req) next_dbg_mode = dtspm_pkg::DTSPM_SWD;
      dtspm_pkg::DTSPM_SWD:  next_dbg_mode = dtspm_pkg::DTSPM_SWD;
      default:               next_dbg_mode = dtspm_pkg::DTSPM_JTAG;
    endcase
    if (!rstn_sync[0]) begin
      next_dbg_mode = dtspm_pkg::DTSPM_JTAG;
      next_strap_n  = pad_sync[0];
    end
    // Strap is tracked while the pin reset is held, frozen after release
    next_fib = !strap_n;
    next_swd = (dbg_mode == dtspm_pkg::DTSPM_SWD);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dbg_mode                   <= dtspm_pkg::DTSPM_JTAG;
      strap_n                    <= 1'b1;
      factory_info_block_monitor <= 1'b0;
      debug_swd_mode             <= 1'b0;
    end else begin
      dbg_mode                   <= next_dbg_mode;
      strap_n                    <= next_strap_n;
      factory_info_block_monitor <= next_fib;
      debug_swd_mode             <= next_swd;
    end
  end

  // Select decode
  logic       swd;
  logic       dbg_off;
  logic       a5_alt;
  logic       b0_alt;
  logic       b1_alt;
  logic       c2_alt;
  logic       sc_uart;
  logic       sc_spi_slave;

  always_comb begin
    swd          = (dbg_mode == dtspm_pkg::DTSPM_SWD);
    dbg_off      = debug_pin_config[dtspm_pkg::DBG_GPIO_BIT];
    a5_alt       = port_a_high_config[dtspm_pkg::PA_HI_PIN5_LSB +: 4] == dtspm_pkg::ALT_OUT_CODE;
    b1_alt       = port_b_low_config[dtspm_pkg::PB_LO_PIN1_LSB +: 4] == dtspm_pkg::ALT_OUT_CODE;
    b0_alt       = port_b_low_config[dtspm_pkg::PB_LO_PIN0_LSB +: 4] == dtspm_pkg::ALT_OUT_CODE;
    c2_alt       = port_c_low_config[dtspm_pkg::PC_LO_PIN2_LSB +: 4] == dtspm_pkg::ALT_OUT_CODE;
    sc_uart      = serctl1_mode_select == dtspm_pkg::SC_MODE_UART;
    sc_spi_slave = serctl1_mode_select == dtspm_pkg::SC_MODE_SPI && serctl1_spi_control;
  end

  // Pad drive; gpio index follows the pad vector order, except bit 3, which drives port B line 1
  dtspm_pkg::dtspm_pad_t next_a5, next_b0, next_b1, next_b2, next_clk, next_c2, next_c3, next_c4;

  always_comb begin
    // Port logic by default; the debug clock pin is only pulled down
    next_a5  = '{gpio_out[0], gpio_oe[0], 1'b0, 1'b0};
    next_b0  = '{gpio_out[1], gpio_oe[1], 1'b0, 1'b0};
    next_b1  = '{1'b0, 1'b0, 1'b0, 1'b0};
    next_b2  = '{gpio_out[2], gpio_oe[2], 1'b0, 1'b0};
    next_clk = '{1'b0, 1'b0, 1'b0, 1'b1};
    next_c2  = '{gpio_out[4], gpio_oe[4], 1'b0, 1'b0};
    next_c3  = '{gpio_out[5], gpio_oe[5], 1'b0, 1'b0};
    next_c4  = '{gpio_out[6], gpio_oe[6], 1'b0, 1'b0};
    // Port B line 1 has no pad input here; gpio bit 3 drives it
    next_b1  = '{gpio_out[3], gpio_oe[3], 1'b0, 1'b0};
    if (a5_alt) begin
      if (trace_cfg.trace_en && trace_cfg.sync_width == dtspm_pkg::TRACE_WIDTH_4) begin
        next_a5 = '{trace_data_bit3, 1'b1, 1'b0, 1'b0};
      end else if (!trace_cfg.trace_en && packet_trace_interface) begin
        next_a5 = '{packet_trace_data_out, 1'b1, 1'b0, 1'b0};
      end
    end
    if (b0_alt && trace_cfg.trace_en) begin
      next_b0 = '{sync_trace_clock, 1'b1, 1'b0, 1'b0};
    end
    if (b1_alt) begin
      if (sc_uart) next_b1 = '{serctl1_uart_tx, 1'b1, 1'b0, 1'b0};
      else if (sc_spi_slave) next_b1 = '{serctl1_spi_slave_out, 1'b1, 1'b0, 1'b0};
    end
    // Clock pin loses its pull-down in serial-wire mode
    if (swd) next_clk = '{1'b0, 1'b0, 1'b0, 1'b0};
    if (!dbg_off) begin
      if (swd) begin
        if (c2_alt && trace_cfg.trace_en && trace_cfg.async_en) begin
          next_c2 = '{swo_trace, 1'b1, 1'b1, 1'b0};
        end
        next_c4 = '{swdio_out, swdio_oe, 1'b1, 1'b0};
      end else begin
        next_c2 = '{jtag_data_out, jtag_data_out_en, 1'b0, 1'b0};
        next_c3 = '{1'b0, 1'b0, 1'b1, 1'b0};
        next_c4 = '{1'b0, 1'b0, 1'b1, 1'b0};
      end
    end
  end

  // Registered pads so every output comes from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pad_a5      <= '0;
      pad_b0      <= '0;
      pad_b1      <= '0;
      pad_b2      <= '0;
      pad_dbg_clk <= '{1'b0, 1'b0, 1'b0, 1'b1};
      pad_c2      <= '0;
      pad_c3      <= '{1'b0, 1'b0, 1'b1, 1'b0};
      pad_c4      <= '{1'b0, 1'b0, 1'b1, 1'b0};
    end else begin
      pad_a5      <= next_a5;
      pad_b0      <= next_b0;
      pad_b1      <= next_b1;
      pad_b2      <= next_b2;
      pad_dbg_clk <= next_clk;
      pad_c2      <= next_c2;
      pad_c3      <= next_c3;
      pad_c4      <= next_c4;
    end
  end

  // Inputs to peripherals; unselected UART, JTAG data and mode and SWDIO inputs see idle high, clocks and SPI slave input see low
  logic [15:0] next_in;

  always_comb begin
    next_in[0]  = sc_spi_slave ? pad_sync[2] : 1'b0;
    next_in[1]  = sc_uart ? pad_sync[2] : 1'b1;
    next_in[2]  = !swd ? pad_sync[3] : 1'b0;
    next_in[3]  = (!swd && !dbg_off) ? pad_sync[5] : 1'b1;
    next_in[4]  = (!swd && !dbg_off) ? pad_sync[6] : 1'b1;
    next_in[5]  = swd ? pad_sync[3] : 1'b0;
    next_in[6]  = (swd && !dbg_off) ? pad_sync[6] : 1'b1;
    next_in[7]  = pad_sync[1];
    next_in[15:8] = {1'b0, pad_sync};
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serctl1_spi_slave_in <= 1'b0;
      serctl1_uart_rx      <= 1'b1;
      jtag_clock_in        <= 1'b0;
      jtag_data_in         <= 1'b1;
      jtag_mode_select     <= 1'b1;
      swclk_in             <= 1'b0;
      swdio_in             <= 1'b1;
      ext_interrupt_a      <= 1'b0;
      gpio_in              <= '0;
    end else begin
      serctl1_spi_slave_in <= next_in[0];
      serctl1_uart_rx      <= next_in[1];
      jtag_clock_in        <= next_in[2];
      jtag_data_in         <= next_in[3];
      jtag_mode_select     <= next_in[4];
      swclk_in             <= next_in[5];
      swdio_in             <= next_in[6];
      ext_interrupt_a      <= next_in[7];
      gpio_in              <= next_in[14:8];
    end
  end

  // Checks
  a_a5_needs_select: assert property (@(posedge clk_sys) disable iff (reset)
    !a5_alt |=> pad_a5.oe == $past(gpio_oe[0]) && pad_a5.dout == $past(gpio_out[0]))
    else $error("port A line 5 driven without alternate select");
  a_jtag_after_reset: assert property (@(posedge clk_sys) disable iff (reset)
    !rstn_sync[0] |=> dbg_mode == dtspm_pkg::DTSPM_JTAG)
    else $error("debug mode not JTAG after pin reset");
  a_swd_switch_mode: assert property (@(posedge clk_sys) disable iff (reset)
    rstn_sync[0] && swd_switch_req |=> dbg_mode == dtspm_pkg::DTSPM_SWD ##1 debug_swd_mode)
    else $error("switch request did not enter serial-wire mode");
  a_irq_follows_pin: assert property (@(posedge clk_sys) disable iff (reset)
    ext_interrupt_a == $past(pad_sync[1]))
    else $error("interrupt A does not follow port B line 0");
  a_strap_frozen_run: assert property (@(posedge clk_sys) disable iff (reset)
    rstn_sync[0] && $past(rstn_sync[0]) |-> $stable(strap_n))
    else $error("boot strap changed after reset release");
  a_c3_free_swd: assert property (@(posedge clk_sys) disable iff (reset)
    swd || dbg_off |=> jtag_data_in && pad_c3.oe == $past(gpio_oe[5]))
    else $error("line C3 not freed");
  a_b1_uart_tx: assert property (@(posedge clk_sys) disable iff (reset)
    b1_alt && sc_uart |=> pad_b1.oe && pad_b1.dout == $past(serctl1_uart_tx))
    else $error("port B line 1 not carrying UART transmit");
  a_dbg_clk_pull: assert property (@(posedge clk_sys) disable iff (reset)
    !swd |=> pad_dbg_clk.pd)
    else $error("debug clock pull-down missing in JTAG mode");
endmodule : dtspm_pin_mux
`default_nettype wire

// *** testbench/dtspm_peer_model.sv ***
// Far-side model: debugger, trace probe and serial peer on the seven pads.
// Assumes pad structs come straight from the multiplexer, index order of pad_in.
`timescale 1ns/1ns
`default_nettype none
module dtspm_peer_model (
  input  wire logic                        clk_sys,
  input  wire dtspm_pkg::dtspm_pad_t [6:0] pads,
  input  wire logic [6:0]                  drv_en,
  input  wire logic [6:0]                  drv_val,
  input  wire logic                        do_switch,
  output var  logic [6:0]                  pad_in,
  output var  logic                        swd_switch_req
);
  logic toggle = 1'b0;
  logic last_switch = 1'b0;

  // Wire level: peer, then device, then pulls; a floating line wanders
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pad_in[i] = drv_en[i] ? drv_val[i] : pads[i].oe ? pads[i].dout :
                  pads[i].pu ? 1'b1 : pads[i].pd ? 1'b0 : toggle;
    end
  end

  // Debugger switch sequence, reported as one pulse per request
  always @(posedge clk_sys) begin
    toggle <= ~toggle;
    last_switch <= do_switch;
    swd_switch_req <= do_switch & ~last_switch;
  end
endmodule : dtspm_peer_model
`default_nettype wire

// *** testbench/dtspm_pin_mux_tb.sv ***
// Self-checking bench for the pin multiplexer, with the peer model on the pads.
// Assumes registered pads (1 cycle) and synchronised pad inputs (3 cycles).
`timescale 1ns/1ns
`default_nettype none
module dtspm_pin_mux_tb;
  logic clk_sys = 1'b0;
  logic reset, pin_reset_n, packet_trace_interface, packet_trace_data_out, trace_data_bit3;
  logic sync_trace_clock, swo_trace, serctl1_spi_control, serctl1_spi_slave_out, serctl1_uart_tx;
  logic swd_switch_req, jtag_data_out, jtag_data_out_en, swdio_out, swdio_oe, do_switch;
  logic [15:0] port_a_high_config, port_b_low_config, port_c_low_config, debug_pin_config;
  logic [1:0] serctl1_mode_select;
  logic [6:0] gpio_out, gpio_oe, pad_in, gpio_in, drv_en, drv_val;
  dtspm_pkg::dtspm_trace_t trace_cfg;
  dtspm_pkg::dtspm_pad_t pad_a5, pad_b0, pad_b1, pad_b2, pad_dbg_clk, pad_c2, pad_c3, pad_c4;
  logic serctl1_spi_slave_in, serctl1_uart_rx, jtag_clock_in, jtag_data_in, jtag_mode_select;
  logic swclk_in, swdio_in, ext_interrupt_a, factory_info_block_monitor, debug_swd_mode;
  int fails = 0;
  int checks_done = 0;

  dtspm_pin_mux dut_u (
    .clk_sys(clk_sys), .reset(reset), .pin_reset_n(pin_reset_n), .port_a_high_config(port_a_high_config),
    .port_b_low_config(port_b_low_config), .port_c_low_config(port_c_low_config),
    .debug_pin_config(debug_pin_config), .trace_cfg(trace_cfg), .packet_trace_interface(packet_trace_interface),
    .packet_trace_data_out(packet_trace_data_out), .trace_data_bit3(trace_data_bit3),
    .sync_trace_clock(sync_trace_clock), .swo_trace(swo_trace), .serctl1_mode_select(serctl1_mode_select),
    .serctl1_spi_control(serctl1_spi_control), .serctl1_spi_slave_out(serctl1_spi_slave_out),
    .serctl1_uart_tx(serctl1_uart_tx), .swd_switch_req(swd_switch_req), .jtag_data_out(jtag_data_out),
    .jtag_data_out_en(jtag_data_out_en), .swdio_out(swdio_out), .swdio_oe(swdio_oe), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pad_in(pad_in), .pad_a5(pad_a5), .pad_b0(pad_b0), .pad_b1(pad_b1), .pad_b2(pad_b2),
    .pad_dbg_clk(pad_dbg_clk), .pad_c2(pad_c2), .pad_c3(pad_c3), .pad_c4(pad_c4),
    .serctl1_spi_slave_in(serctl1_spi_slave_in), .serctl1_uart_rx(serctl1_uart_rx),
    .jtag_clock_in(jtag_clock_in), .jtag_data_in(jtag_data_in), .jtag_mode_select(jtag_mode_select),
    .swclk_in(swclk_in), .swdio_in(swdio_in), .ext_interrupt_a(ext_interrupt_a), .gpio_in(gpio_in),
    .factory_info_block_monitor(factory_info_block_monitor), .debug_swd_mode(debug_swd_mode)
  );

  dtspm_peer_model peer_u (
    .clk_sys(clk_sys), .pads({pad_c4, pad_c3, pad_c2, pad_dbg_clk, pad_b2, pad_b0, pad_a5}),
    .drv_en(drv_en), .drv_val(drv_val), .do_switch(do_switch), .pad_in(pad_in), .swd_switch_req(swd_switch_req)
  );

  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Inputs always change 1 ns after the edge, so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // A pin reset pulse with the strap level held on the A5 line
  task automatic pin_reset(input logic strap);
    drv_val[0] = strap;
    pin_reset_n = 1'b0;
    tick(5);
    pin_reset_n = 1'b1;
    tick(5);
  endtask : pin_reset

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    stop_test();
  end

  // Main sequence
  initial begin
    reset = 1'b1; pin_reset_n = 1'b1; do_switch = 1'b0;
    port_a_high_config = 16'h0000; port_b_low_config = 16'h0000;
    port_c_low_config = 16'h0000; debug_pin_config = 16'h0000; trace_cfg = 4'h0;
    packet_trace_interface = 1'b1; packet_trace_data_out = 1'b1; trace_data_bit3 = 1'b0;
    sync_trace_clock = 1'b1; swo_trace = 1'b1; serctl1_mode_select = dtspm_pkg::SC_MODE_UART;
    serctl1_spi_control = 1'b1; serctl1_spi_slave_out = 1'b0; serctl1_uart_tx = 1'b1;
    jtag_data_out = 1'b0; jtag_data_out_en = 1'b1; swdio_out = 1'b0; swdio_oe = 1'b0;
    gpio_out = 7'h34; gpio_oe = 7'h7f; drv_en = 7'h6f; drv_val = 7'h68;
    tick(2);
    reset = 1'b0;
    tick(6);
    chk(debug_swd_mode, 1'b0);
    chk(pad_dbg_clk.pd, 1'b1);
    chk({pad_c3.pu, pad_c4.pu}, 2'h3);
    chk(factory_info_block_monitor, 1'b1);
    // Port A line 5: packet trace, 4-wire trace, then port logic
    port_a_high_config = {8'h00, dtspm_pkg::ALT_OUT_CODE, 4'h0};
    tick(1);
    chk({pad_a5.dout, pad_a5.oe}, 2'h3);
    trace_cfg = {1'b1, 1'b0, dtspm_pkg::TRACE_WIDTH_4};
    tick(1);
    chk({pad_a5.dout, pad_a5.oe}, 2'h1);
    trace_cfg = {1'b1, 1'b0, 2'h2};
    trace_data_bit3 = 1'b1;
    tick(1);
    chk({pad_a5.dout, pad_a5.oe}, 2'h1);
    trace_cfg = 4'h0;
    port_a_high_config = 16'h0080;
    tick(1);
    chk({pad_a5.dout, pad_a5.oe}, 2'h1);
    // Port B line 1 and line 2 in UART, SPI slave and off modes
    port_b_low_config = {8'h00, dtspm_pkg::ALT_OUT_CODE, 4'h0};
    drv_val[2] = 1'b1;
    tick(3);
    chk({pad_b1.dout, pad_b1.oe}, 2'h3);
    chk(serctl1_uart_rx, 1'b1);
    drv_val[2] = 1'b0;
    tick(3);
    chk(serctl1_uart_rx, 1'b0);
    serctl1_mode_select = dtspm_pkg::SC_MODE_SPI;
    drv_val[2] = 1'b1;
    tick(3);
    chk({pad_b1.dout, pad_b1.oe}, 2'h1);
    chk(serctl1_spi_slave_in, 1'b1);
    serctl1_mode_select = dtspm_pkg::SC_MODE_OFF;
    tick(1);
    chk({pad_b1.dout, pad_b1.oe}, 2'h1);
    chk({pad_b2.dout, pad_b2.oe}, 2'h3);
    // Port B line 0: interrupt input and trace clock
    drv_val[1] = 1'b1;
    tick(3);
    chk(ext_interrupt_a, 1'b1);
    drv_val[1] = 1'b0;
    tick(3);
    chk(ext_interrupt_a, 1'b0);
    drv_en[1] = 1'b0;
    port_b_low_config = {12'h000, dtspm_pkg::ALT_OUT_CODE};
    trace_cfg = {1'b1, 1'b0, 2'h0};
    tick(1);
    chk({pad_b0.dout, pad_b0.oe}, 2'h3);
    trace_cfg = 4'h0;
    tick(1);
    chk({pad_b0.dout, pad_b0.oe}, 2'h1);
    // JTAG inputs, then the debug-disable bit frees lines C2 to C4
    tick(2);
    chk({jtag_clock_in, jtag_data_in, jtag_mode_select}, 3'h7);
    chk({pad_c2.dout, pad_c2.oe}, 2'h1);
    debug_pin_config = 16'h0020;
    drv_val[5] = 1'b0;
    tick(3);
    chk({pad_c2.dout, pad_c2.oe, pad_c4.dout, pad_c4.oe}, 4'hd);
    chk({pad_c3.dout, pad_c3.oe}, 2'h3);
    chk({gpio_in[5], jtag_data_in}, 2'h1);
    // Serial-wire mode by debugger request, with asynchronous trace on C2
    debug_pin_config = 16'h0000;
    do_switch = 1'b1;
    tick(4);
    do_switch = 1'b0;
    chk(debug_swd_mode, 1'b1);
    chk(swclk_in, 1'b1);
    chk({pad_c4.dout, pad_c4.oe, pad_c4.pu, swdio_in}, 4'h3);
    chk({pad_c3.dout, pad_c3.oe}, 2'h3);
    port_c_low_config = {4'h0, dtspm_pkg::ALT_OUT_CODE, 8'h00};
    trace_cfg = {1'b1, 1'b1, 2'h0};
    tick(1);
    chk({pad_c2.dout, pad_c2.oe, pad_c2.pu}, 3'h7);
    // Pin reset returns JTAG and samples an inactive strap
    pin_reset(1'b1);
    chk(debug_swd_mode, 1'b0);
    chk({pad_c2.dout, pad_c2.oe}, 2'h1);
    chk(factory_info_block_monitor, 1'b0);
    stop_test();
  end
endmodule : dtspm_pin_mux_tb
`default_nettype wire
